// ---- ccal_regs.sv ----
/*
  Channel-five calibration register bank with Avalon-MM slave and corrector.
  Assumes a 100 MHz clock, synchronous active-high reset and a master that
  holds each request until it sees waitrequest low.
*/
// Notes on behaviour
// R01 - offset high word, bits 23:8, reset 0000h
// R02 - offset low byte in 15:8, rest zero
// R03 - offset word is signed two's complement
// R04 - gain high word, bits 23:8, reset 8000h
// R05 - gain low byte in 15:8, reset zero
// R06 - gain unsigned, 0 to under 2.0
// R07 - subtract offset, scale by gain, saturate
`timescale 1ns/1ps
`default_nettype none
module ccal_regs
(
  input  wire logic                                clk_in,
  input  wire logic                                rst_in,
  input  wire logic [ccal_pkg::CCAL_AV_ADDR_W-1:0] avs_address_in,
  input  wire logic                                avs_read_in,
  input  wire logic                                avs_write_in,
  input  wire logic [ccal_pkg::CCAL_AV_DATA_W-1:0] avs_writedata_in,
  input  wire logic [3:0]                          avs_byteenable_in,
  output logic      [ccal_pkg::CCAL_AV_DATA_W-1:0] avs_readdata_out,
  output logic                                     avs_waitrequest_out,
  output logic                                     avs_readdatavalid_out,
  input  wire logic                                sample_valid_in,
  input  wire logic [ccal_pkg::CCAL_DATA_W-1:0]    sample_in,
  output logic                                     result_valid_out,
  output logic      [ccal_pkg::CCAL_DATA_W-1:0]    result_out
);
  import ccal_pkg::*;

  logic [15:0]             ch5_offset_upper_bits;
  logic [7:0]              ch5_offset_lower_bits;
  logic [15:0]             ch5_gain_upper_bits;
  logic [7:0]              ch5_gain_lower_bits;
  logic                    served;
  logic [15:0]             sample_count;
  logic [CCAL_DATA_W-1:0]  core_result;
  logic                    core_valid;
  logic [7:0]              word_idx;
  logic                    req;
  logic [15:0]             wmask;
  logic [15:0]             wdata;

  // address decoding used by the read path; the write path decodes word_idx in its own case
  function automatic logic is_mapped(input logic [7:0] idx);
    return idx == CCAL_IDX_OFS_HI || idx == CCAL_IDX_OFS_LO
        || idx == CCAL_IDX_GAIN_HI || idx == CCAL_IDX_GAIN_LO
        || idx == CCAL_IDX_STATUS;
  endfunction

  always_comb begin
    word_idx = {2'h0, avs_address_in[7:2]};
    req      = (avs_read_in || avs_write_in) && !served;
    wmask    = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    wdata    = avs_writedata_in[15:0];
  end

  // one wait state: waitrequest drops the cycle after the request appears;
  // held in its own flop, the inverse of served, so the pin is registered
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      served              <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      served              <= req;
      avs_waitrequest_out <= !req;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ch5_offset_upper_bits <= CCAL_RST_OFS_HI; // [R01]
      ch5_offset_lower_bits <= CCAL_RST_OFS_LO;
      ch5_gain_upper_bits   <= CCAL_RST_GAIN_HI; // [R04]
      ch5_gain_lower_bits   <= CCAL_RST_GAIN_LO; // [R05]
    end else if (served && avs_write_in) begin
      unique case (word_idx)
        CCAL_IDX_OFS_HI: begin
          ch5_offset_upper_bits <= (ch5_offset_upper_bits & ~wmask) | (wdata & wmask); // [R01]
        end
        CCAL_IDX_OFS_LO: begin
          if (avs_byteenable_in[1]) ch5_offset_lower_bits <= wdata[15:8]; // [R02]
        end
        CCAL_IDX_GAIN_HI: begin
          ch5_gain_upper_bits <= (ch5_gain_upper_bits & ~wmask) | (wdata & wmask); // [R04]
        end
        CCAL_IDX_GAIN_LO: begin
          if (avs_byteenable_in[1]) ch5_gain_lower_bits <= wdata[15:8]; // [R05]
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sample_count <= 16'h0000;
    end else if (core_valid) begin
      sample_count <= sample_count + 16'h0001;
    end
  end

  // readdata registered on the acceptance edge; bits 31:16, low-register bits 7:0 and unmapped words read zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      avs_readdata_out      <= 32'h0000_0000;
      avs_readdatavalid_out <= 1'b0;
    end else begin
      avs_readdatavalid_out <= req && avs_read_in;
      if (req && avs_read_in) begin
        if (!is_mapped(word_idx)) begin
          avs_readdata_out <= 32'h0000_0000;
        end else begin
          unique case (word_idx)
            CCAL_IDX_OFS_HI:  avs_readdata_out <= {16'h0000, ch5_offset_upper_bits};
            CCAL_IDX_OFS_LO:  avs_readdata_out <= {16'h0000, ch5_offset_lower_bits, 8'h00}; // [R02]
            CCAL_IDX_GAIN_HI: avs_readdata_out <= {16'h0000, ch5_gain_upper_bits};
            CCAL_IDX_GAIN_LO: avs_readdata_out <= {16'h0000, ch5_gain_lower_bits, 8'h00}; // [R05]
            default:          avs_readdata_out <= {16'h0000, sample_count};
          endcase
        end
      end
    end
  end

  ccal_corrector #(
    .DATA_W (CCAL_DATA_W)
  ) u_corrector (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .valid_in   (sample_valid_in),
    .sample_in  (sample_in),
    .offset_in  ({ch5_offset_upper_bits, ch5_offset_lower_bits}), // [R03]
    .gain_in    ({ch5_gain_upper_bits, ch5_gain_lower_bits}), // [R06]
    .valid_out  (core_valid),
    .result_out (core_result)
  );

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      result_valid_out <= 1'b0;
      result_out       <= '0;
    end else begin
      result_valid_out <= core_valid;
      result_out       <= core_result; // [R07]
    end
  end

  AST_OFS_HI_RESET: assert property (@(posedge clk_in) // [R01]
    rst_in |=> ch5_offset_upper_bits == 16'h0000)
    else $error("offset high not zero after reset");

  AST_OFS_HI_WRITE: assert property (@(posedge clk_in) disable iff (rst_in) // [R01]
    served && avs_write_in && word_idx == CCAL_IDX_OFS_HI && avs_byteenable_in[1:0] == 2'h3
    |=> ch5_offset_upper_bits == $past(avs_writedata_in[15:0]))
    else $error("offset high write lost");

  AST_OFS_LO_READ: assert property (@(posedge clk_in) disable iff (rst_in) // [R02]
    req && avs_read_in && word_idx == CCAL_IDX_OFS_LO
    |=> avs_readdata_out == {16'h0000, $past(ch5_offset_lower_bits), 8'h00})
    else $error("offset low readback wrong");

  AST_SIGNED_OFFSET: assert property (@(posedge clk_in) disable iff (rst_in) // [R03]
    sample_valid_in && sample_in == 24'h000000 && ch5_offset_upper_bits[15]
    && ch5_gain_upper_bits == 16'h8000 && ch5_gain_lower_bits == 8'h00
    && $stable(ch5_offset_upper_bits) ##1 $stable(ch5_gain_upper_bits)
    |-> ##2 result_valid_out && !result_out[23])
    else $error("negative offset not treated as signed");

  AST_GAIN_HI_RESET: assert property (@(posedge clk_in) // [R04]
    rst_in |=> ch5_gain_upper_bits == 16'h8000)
    else $error("gain high not 8000h after reset");

  AST_GAIN_LO_READ: assert property (@(posedge clk_in) disable iff (rst_in) // [R05]
    req && avs_read_in && word_idx == CCAL_IDX_GAIN_LO |=> avs_readdata_out[7:0] == 8'h00)
    else $error("gain low reserved bits not zero");

  AST_UNITY_GAIN: assert property (@(posedge clk_in) disable iff (rst_in) // [R06]
    sample_valid_in && {ch5_offset_upper_bits, ch5_offset_lower_bits} == 24'h000000
    && {ch5_gain_upper_bits, ch5_gain_lower_bits} == 24'h800000
    ##1 $stable({ch5_gain_upper_bits, ch5_offset_upper_bits, ch5_offset_lower_bits})
    |-> ##2 result_valid_out && result_out == $past(sample_in, 3))
    else $error("unity gain does not pass sample through");

  AST_SATURATE: assert property (@(posedge clk_in) disable iff (rst_in) // [R07]
    sample_valid_in && sample_in == 24'h7fffff
    && {ch5_offset_upper_bits, ch5_offset_lower_bits} == 24'h000000
    && {ch5_gain_upper_bits, ch5_gain_lower_bits} == 24'hffffff
    ##1 $stable({ch5_gain_upper_bits, ch5_gain_lower_bits})
    |-> ##2 result_valid_out && result_out == 24'h7fffff)
    else $error("positive overflow not clamped to full scale");

  AST_SAT_LOW: assert property (@(posedge clk_in) disable iff (rst_in) // [R07]
    sample_valid_in && sample_in == 24'h800000
    && {ch5_offset_upper_bits, ch5_offset_lower_bits} == 24'h000000
    && {ch5_gain_upper_bits, ch5_gain_lower_bits} == 24'hffffff
    ##1 $stable({ch5_gain_upper_bits, ch5_gain_lower_bits})
    |-> ##2 result_valid_out && result_out == 24'h800000)
    else $error("negative overflow not clamped to full scale");

  AST_LATENCY: assert property (@(posedge clk_in) disable iff (rst_in) // [R07]
    sample_valid_in |-> ##3 result_valid_out)
    else $error("result valid latency not three cycles");

  AST_WAIT_ONE: assert property (@(posedge clk_in) disable iff (rst_in)
    req |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("waitrequest not released for exactly one cycle");
endmodule
`default_nettype wire

// ---- ccal_pkg.sv ----
/*
  Package for the channel-five calibration register block: register offsets,
  field layout, reset values and datapath widths.
  Assumes nothing of its surroundings; imported by both design files.
*/
package ccal_pkg;
  localparam int          CCAL_DATA_W      = 24;
  localparam int          CCAL_REG_W       = 16;
  localparam int          CCAL_AV_ADDR_W   = 8;
  localparam int          CCAL_AV_DATA_W   = 32;
  // printed word indices; byte address is four times the index
  localparam logic [7:0]  CCAL_IDX_OFS_HI  = 8'h23;
  localparam logic [7:0]  CCAL_IDX_OFS_LO  = 8'h24;
  localparam logic [7:0]  CCAL_IDX_GAIN_HI = 8'h25;
  localparam logic [7:0]  CCAL_IDX_GAIN_LO = 8'h26;
  localparam logic [7:0]  CCAL_IDX_STATUS  = 8'h28;
  localparam logic [15:0] CCAL_RST_OFS_HI  = 16'h0000;
  localparam logic [7:0]  CCAL_RST_OFS_LO  = 8'h00;
  localparam logic [15:0] CCAL_RST_GAIN_HI = 16'h8000;
  localparam logic [7:0]  CCAL_RST_GAIN_LO = 8'h00;
  localparam int          CCAL_LO_FIELD_MSB = 15;
  localparam int          CCAL_LO_FIELD_LSB = 8;
  // gain has 23 fractional bits: 0x800000 is unity
  localparam int          CCAL_GAIN_FRAC   = 23;
  localparam int          CCAL_PIPE_STAGES = 2;
endpackage

// ---- ccal_corrector.sv ----
/*
  Offset and gain corrector for channel-five samples: subtract the signed
  offset, multiply by the unsigned gain, saturate to 24 bits.
  Assumes one sample per valid pulse on the shared clock; two-cycle latency.
*/
`timescale 1ns/1ps
`default_nettype none
module ccal_corrector
#(
  parameter int DATA_W = ccal_pkg::CCAL_DATA_W
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              valid_in,
  input  wire logic [DATA_W-1:0] sample_in,
  input  wire logic [DATA_W-1:0] offset_in,
  input  wire logic [DATA_W-1:0] gain_in,
  output logic                   valid_out,
  output logic      [DATA_W-1:0] result_out
);
  import ccal_pkg::*;

  localparam logic signed [DATA_W+1:0] SAT_MAX = (DATA_W+2)'((1 << (DATA_W-1)) - 1);
  localparam logic signed [DATA_W+1:0] SAT_MIN = -(DATA_W+2)'(1 << (DATA_W-1));

  // the fixed-point scaling is built for 24-bit words only
  if (DATA_W != CCAL_DATA_W) begin : g_width_check
    $error("ccal_corrector: DATA_W must be 24");
  end

  logic signed [DATA_W:0]          diff;
  logic signed [2*DATA_W+1:0]      prod;
  logic signed [DATA_W+1:0]        scaled;
  logic                            stage_valid;

  // product kept combinational so data and valid both take two flops
  always_comb begin
    // signed offset, unsigned gain widened with a zero sign bit
    prod   = $signed(diff) * $signed({1'b0, gain_in}); // [R03] [R06] [R07]
    scaled = (DATA_W+2)'(prod >>> CCAL_GAIN_FRAC);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      diff        <= '0;
      stage_valid <= 1'b0;
    end else begin
      diff        <= $signed({sample_in[DATA_W-1], sample_in})
                   - $signed({offset_in[DATA_W-1], offset_in}); // [R03] [R07]
      stage_valid <= valid_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_out  <= 1'b0;
      result_out <= '0;
    end else begin
      valid_out <= stage_valid;
      if (scaled > SAT_MAX) begin
        result_out <= SAT_MAX[DATA_W-1:0]; // [R07]
      end else if (scaled < SAT_MIN) begin
        result_out <= SAT_MIN[DATA_W-1:0];
      end else begin
        result_out <= scaled[DATA_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// ---- test_ccal_regs.sv ----
/*
  Self-checking bench for the channel-five calibration register bank.
  Assumes the ccal_pkg package and the ccal_regs module are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_ccal_regs;
  import ccal_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  avs_address_in = 8'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        avs_readdatavalid_out;
  logic        sample_valid_in = 1'b0;
  logic [23:0] sample_in = 24'h0;
  logic        result_valid_out;
  logic [23:0] result_out;
  int          error_cnt = 0;
  int          checks = 0;
  logic [31:0] rd;
  logic [7:0]  row_a [5] = '{8'h8c, 8'h90, 8'h94, 8'h98, 8'hfc};
  logic [15:0] row_w [5] = '{16'ha5c3, 16'h7e5a, 16'hffff, 16'h12ff, 16'h1234};
  logic [31:0] row_e [5] = '{32'ha5c3, 32'h7e00, 32'hffff, 32'h1200, 32'h0};
  logic [15:0] rst_e [4] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000};

  ccal_regs i_ccal_regs (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .avs_readdatavalid_out(avs_readdatavalid_out), .sample_valid_in(sample_valid_in),
    .sample_in(sample_in), .result_valid_out(result_valid_out), .result_out(result_out));

  always #5 clk_in = ~clk_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_write_in      <= wr;
    avs_read_in       <= !wr;
    avs_address_in    <= a;
    avs_writedata_in  <= {16'h0, d};
    avs_byteenable_in <= be;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    q = avs_readdata_out;
    if (n >= 50) check(32'h1, 32'h0);
    if (!wr) check({31'h0, avs_readdatavalid_out}, 32'h1);
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask

  function automatic logic [23:0] model(input logic [23:0] s, input logic [23:0] o,
                                        input logic [23:0] g);
    longint d;
    longint p;
    d = longint'($signed(s)) - longint'($signed(o));
    p = (d * longint'({40'h0, g})) >>> 23;
    if (p > 8388607) return 24'h7fffff;
    if (p < -8388608) return 24'h800000;
    return p[23:0];
  endfunction

  // sets calibration, sends one sample and checks the result three cycles later
  task automatic corr(input logic [23:0] o, input logic [23:0] g, input logic [23:0] s);
    logic [31:0] q;
    bus(1'b1, 8'h8c, o[23:8], 4'hf, q);
    bus(1'b1, 8'h90, {o[7:0], 8'h00}, 4'hf, q);
    bus(1'b1, 8'h94, g[23:8], 4'hf, q);
    bus(1'b1, 8'h98, {g[7:0], 8'h00}, 4'hf, q);
    @(posedge clk_in);
    sample_valid_in <= 1'b1;
    sample_in       <= s;
    @(posedge clk_in);
    sample_valid_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check({31'h0, result_valid_out}, 32'h1);
    check({8'h0, result_out}, {8'h0, model(s, o, g)});
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, row_a[i], row_w[i], 4'hf, rd);
      bus(1'b0, row_a[i], 16'h0, 4'hf, rd);
      check(rd, row_e[i]);
    end
    $display("test register rows done");
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    check({31'h0, avs_waitrequest_out}, 32'h1);
    check({31'h0, result_valid_out}, 32'h0);
    check({8'h0, result_out}, 32'h0);
    rst_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'h8c + 8'(4 * i), 16'h0, 4'hf, rd);
      check(rd, {16'h0, rst_e[i]});
    end
    @(posedge clk_in);
    sample_valid_in <= 1'b1;
    sample_in       <= 24'h123456;
    @(posedge clk_in);
    sample_valid_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check({31'h0, result_valid_out}, 32'h1);
    check({8'h0, result_out}, 32'h123456);
    bus(1'b0, 8'ha0, 16'h0, 4'hf, rd);
    check(rd, 32'h1);
    $display("test reset values done");
    bus(1'b1, 8'h8c, 16'h5a5a, 4'h2, rd);
    bus(1'b0, 8'h8c, 16'h0, 4'hf, rd);
    check(rd, 32'h5a00);
    bus(1'b1, 8'h98, 16'hffff, 4'h1, rd);
    bus(1'b0, 8'h98, 16'h0, 4'hf, rd);
    check(rd, 32'h0);
    $display("test byte lanes done");
    corr(24'hfffff0, 24'h400000, 24'h000064);
    corr(24'h000000, 24'hffffff, 24'h7fffff);
    corr(24'h000000, 24'hffffff, 24'h800000);
    corr(24'h100000, 24'h800000, 24'h800000);
    corr(24'hfff000, 24'h800000, 24'h000000);
    bus(1'b0, 8'ha0, 16'h0, 4'hf, rd);
    check(rd, 32'h6);
    $display("test corrector done");
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
